// File: shared/eep_consts.vh
`ifndef EEP_CONSTS_VH
`define EEP_CONSTS_VH
// Slave address family code and array geometry
`define EEP_FAMILY_CODE    4'ha
`define EEP_ADDR_W         13
`define EEP_MEM_BYTES      8192
`define EEP_PAGE_BYTES     32
`define EEP_OFFS_W         5
`define EEP_ERASED_BYTE    8'hff
// Programming cycle time in microseconds and clock rate in kHz
`define EEP_PROG_TIME_US   5000
`define EEP_CLK_KHZ        40000
`define EEP_PROG_CYCLES    ((`EEP_PROG_TIME_US * `EEP_CLK_KHZ) / 1000)
`define EEP_PROG_CNT_W     24
`endif

// File: hdl/eep_slave.v
`timescale 1ns/1ps
`include "eep_consts.vh"

// Contract
// - Sample SDA on SCL rise; change output SDA after SCL fall.
// - SDA is open drain: only pulled low or released.
// - START is SDA falling with SCL high; ignore bus until START.
// - STOP is SDA rising with SCL high; ends any command.
// - Address matches 1010 then the three select pins.
// - Eighth address bit: 1 means read, 0 means write.
// - Package without select pins matches only select value 000.
// - Ninth clock: sender releases SDA, receiver pulls low to acknowledge.
// - Byte write: address, two address bytes, data, STOP; each acknowledged.
// - STOP ending a write starts programming; no acknowledge meanwhile.
// - Further data bytes buffered, up to 32, from given address.
// - Page write keeps page fixed and wraps the in-page offset.
// - After STOP all buffered bytes commit in one programming cycle.
// - Write-protect high forbids all writes; low has no effect.
// - Write-protect sampled at last SCL fall before first data byte.
// - Variant without write-protect allows all writes.
// - Array starts with all bytes FFh.
// - Read: acknowledge, send byte at current address; refusal and STOP end.
// - Selective read: write address bytes, then repeated START with read.
// - Master acknowledge on read byte gets next byte until refusal.
// - Sequential reads increment address and wrap at array end.
// - Reset puts the device in standby, ignoring the bus.
module eep_slave #(
	parameter                     HAS_SEL_PINS = 1,
	parameter                     HAS_WP_PIN   = 1,
	parameter [`EEP_PROG_CNT_W-1:0] PROG_CYCLES  = `EEP_PROG_CYCLES
) (
	input  wire       clk,
	input  wire       nrst,
	input  wire       scl_in,
	input  wire       sda_in,
	output wire       sda_out,
	output wire       sda_oe_n,
	input  wire       select_pin_bit0,
	input  wire       select_pin_bit1,
	input  wire       select_pin_bit2,
	input  wire       write_protect,
	output wire       prog_busy
);

	// Phases of a transaction
	// ST_SKIP waits out a refused or finished transfer until the next START or STOP
	localparam [2:0] ST_IDLE = 3'd0;
	localparam [2:0] ST_DEV  = 3'd1;
	localparam [2:0] ST_AHI  = 3'd2;
	localparam [2:0] ST_ALO  = 3'd3;
	localparam [2:0] ST_WDAT = 3'd4;
	localparam [2:0] ST_RDAT = 3'd5;
	localparam [2:0] ST_SKIP = 3'd6;

	// Two-stage synchronisers for bus pins and straps
	// Two stages keep metastability off the sequencer; the price is about three
	// cycles of lag, which the bus phases easily absorb
	reg [1:0] scl_sync_reg;
	reg [1:0] sda_sync_reg;
	reg [1:0] wp_sync_reg;
	reg [2:0] sel_s1_reg;
	reg [2:0] sel_s2_reg;
	reg       scl_d_reg;
	reg       sda_d_reg;

	always @(posedge clk) begin
		if (!nrst) begin
			// Idle bus levels, so the edge finders see nothing right after reset
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			wp_sync_reg  <= 2'h0;
			sel_s1_reg   <= 3'h0;
			sel_s2_reg   <= 3'h0;
			scl_d_reg    <= 1'b1;
			sda_d_reg    <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], scl_in};
			sda_sync_reg <= {sda_sync_reg[0], sda_in};
			wp_sync_reg  <= {wp_sync_reg[0], write_protect};
			sel_s1_reg   <= {select_pin_bit2, select_pin_bit1, select_pin_bit0};
			sel_s2_reg   <= sel_s1_reg;
			scl_d_reg    <= scl_sync_reg[1];
			sda_d_reg    <= sda_sync_reg[1];
		end
	end

	// Synchronised levels and single-cycle edge strobes
	wire scl_s     = scl_sync_reg[1];
	wire sda_s     = sda_sync_reg[1];
	wire scl_rise  = scl_s & ~scl_d_reg;
	wire scl_fall  = ~scl_s & scl_d_reg;
	// Bus conditions only count with SCL steady high
	// Both samples of SCL must be high, so a slow clock edge cannot fake one
	wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	wire stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
	// Strap and protect pins are sampled all the time, not only at START
	// Missing select pins read as 000
	wire [2:0] sel_val = (HAS_SEL_PINS != 0) ? sel_s2_reg : 3'h0;
	wire       wp_val  = (HAS_WP_PIN != 0) ? wp_sync_reg[1] : 1'b0;

	// Array and page buffer in flip-flops
	// Flip-flops keep the erased fill at reset simple, at a large cost in area
	reg [7:0]                mem_reg [0:`EEP_MEM_BYTES-1];
	reg [7:0]                page_reg [0:`EEP_PAGE_BYTES-1];
	reg [`EEP_PAGE_BYTES-1:0] page_vld_reg;

	// Sequencer state, address pointers and the programming timer
	reg [2:0]                 state_reg;
	reg [3:0]                 bit_reg;
	reg [7:0]                 shift_reg;
	reg                       ack_phase_reg;
	reg                       drive_low_reg;
	reg [`EEP_ADDR_W-1:0]     addr_reg;
	reg [4:0]                 addr_hi_reg;
	reg                       wp_lat_reg;
	reg                       rd_nack_reg;
	reg [`EEP_PROG_CNT_W-1:0] prog_cnt_reg;
	reg                       prog_reg;
	reg [`EEP_ADDR_W-1:0]     page_base_reg;
	reg                       commit_reg;
	reg                       was_read_reg;
	integer                   i;

	// Family code and straps are compared on the byte as it stands at the eighth fall
	// Address and offset successors wrap naturally at their widths
	wire dev_match = (shift_reg[7:4] == `EEP_FAMILY_CODE) && (shift_reg[3:1] == sel_val);
	wire [`EEP_ADDR_W-1:0] addr_inc = addr_reg + 13'h0001;
	wire [`EEP_OFFS_W-1:0] offs_inc = addr_reg[`EEP_OFFS_W-1:0] + 5'h01;

	// Bus sequencer; the sampled bit is the one after the rising edge
	// Priority: STOP, then START, then the clock edges of the current phase.
	// The ninth clock runs under ack_phase_reg, so the bit counter stays at 8
	// until the answering bit is over; the line is released on its last fall.
	// While busy, a START lands in ST_SKIP, so nothing on the bus is answered.
	always @(posedge clk) begin
		if (!nrst) begin
			state_reg     <= ST_IDLE;
			bit_reg       <= 4'h0;
			shift_reg     <= 8'h00;
			ack_phase_reg <= 1'b0;
			drive_low_reg <= 1'b0;
			addr_reg      <= {`EEP_ADDR_W{1'b0}};
			addr_hi_reg   <= 5'h00;
			wp_lat_reg    <= 1'b0;
			rd_nack_reg   <= 1'b0;
			page_vld_reg  <= {`EEP_PAGE_BYTES{1'b0}};
			page_base_reg <= {`EEP_ADDR_W{1'b0}};
			commit_reg    <= 1'b0;
			was_read_reg  <= 1'b0;
		end else begin
			commit_reg <= 1'b0;
			if (stop_det) begin
				// STOP ends everything; a buffered write is committed
				// A STOP after address bytes alone finds no valid offset and starts nothing
				state_reg     <= ST_IDLE;
				drive_low_reg <= 1'b0;
				if (|page_vld_reg)
					commit_reg <= 1'b1;
			end else if (start_det) begin
				// Repeated START after address bytes keeps the address
				state_reg     <= prog_reg ? ST_SKIP : ST_DEV;
				bit_reg       <= 4'h0;
				ack_phase_reg <= 1'b0;
				drive_low_reg <= 1'b0;
			end else if (state_reg != ST_IDLE && state_reg != ST_SKIP) begin
				if (scl_rise && !ack_phase_reg) begin
					shift_reg <= {shift_reg[6:0], sda_s};
					bit_reg   <= bit_reg + 4'h1;
				end else if (scl_rise && ack_phase_reg && state_reg == ST_RDAT) begin
					rd_nack_reg <= sda_s;
				end else if (scl_fall && ack_phase_reg) begin
					// End of ninth clock: release line, load next byte if reading
					ack_phase_reg <= 1'b0;
					bit_reg       <= 4'h0;
					drive_low_reg <= 1'b0;
					// The first data byte follows this fall, so protect is taken here
					if (state_reg == ST_WDAT && !(|page_vld_reg))
						wp_lat_reg <= wp_val;
					if (state_reg == ST_RDAT) begin
						if (rd_nack_reg)
							state_reg <= ST_SKIP;
						else begin
							// Next byte goes out now and the pointer moves past it
							shift_reg     <= mem_reg[addr_reg];
							addr_reg      <= addr_inc;
							drive_low_reg <= ~mem_reg[addr_reg][7];
						end
					end
				end else if (scl_fall && state_reg == ST_RDAT && bit_reg != 4'h8) begin
					// Shift next read bit out after the falling edge
					// The register shifted on the rise, so bit 7 now holds the next bit
					drive_low_reg <= ~shift_reg[7];
				end else if (scl_fall && bit_reg == 4'h8) begin
					ack_phase_reg <= 1'b1;
					drive_low_reg <= 1'b0;
					case (state_reg)
						ST_DEV: begin
							if (dev_match) begin
								drive_low_reg <= 1'b1;
								was_read_reg  <= shift_reg[0];
								state_reg     <= shift_reg[0] ? ST_RDAT : ST_AHI;
								if (shift_reg[0]) begin
									rd_nack_reg <= 1'b0;
								end
							end else
								state_reg <= ST_SKIP;
						end
						ST_AHI: begin
							drive_low_reg <= 1'b1;
							addr_hi_reg   <= shift_reg[4:0];
							state_reg     <= ST_ALO;
						end
						ST_ALO: begin
							drive_low_reg <= 1'b1;
							addr_reg      <= {addr_hi_reg, shift_reg};
							page_base_reg <= {addr_hi_reg, shift_reg};
							// Protect level is taken on the fall that ends this acknowledge
							wp_lat_reg    <= 1'b0;
							page_vld_reg  <= {`EEP_PAGE_BYTES{1'b0}};
							state_reg     <= ST_WDAT;
						end
						ST_WDAT: begin
							if (wp_lat_reg) begin
								// Refused byte: no acknowledge, rest of the session ignored
								state_reg <= ST_SKIP;
							end else begin
								drive_low_reg <= 1'b1;
								page_vld_reg[addr_reg[`EEP_OFFS_W-1:0]] <= 1'b1;
								addr_reg[`EEP_OFFS_W-1:0] <= offs_inc;
							end
						end
						ST_RDAT: begin
							// Stay to hear the master's answer on the ninth clock
							state_reg <= ST_RDAT;
						end
						default: state_reg <= ST_SKIP;
					endcase
				end
			end
			// Read direction: first byte goes out on the ACK-ending fall
			if (!stop_det && !start_det && scl_fall && ack_phase_reg && state_reg == ST_RDAT
				&& bit_reg == 4'h0 && !rd_nack_reg) begin
				shift_reg <= mem_reg[addr_reg];
			end
			// Clearing last lets the commit cycle still see which offsets were loaded
			if (commit_reg)
				page_vld_reg <= {`EEP_PAGE_BYTES{1'b0}};
		end
	end

	// Page buffer capture; later bytes at the same offset overwrite
	// It reads the offset before the sequencer advances it on that same edge
	always @(posedge clk) begin
		if (state_reg == ST_WDAT && scl_fall && bit_reg == 4'h8 && !ack_phase_reg
			&& !wp_lat_reg && !stop_det && !start_det)
			page_reg[addr_reg[`EEP_OFFS_W-1:0]] <= shift_reg;
	end

	// Array: erased at reset, loaded page bytes written in one commit
	// Only loaded offsets are written, so a short page leaves its neighbours intact
	always @(posedge clk) begin
		if (!nrst) begin
			for (i = 0; i < `EEP_MEM_BYTES; i = i + 1)
				mem_reg[i] <= `EEP_ERASED_BYTE;
		end else if (commit_reg) begin
			for (i = 0; i < `EEP_PAGE_BYTES; i = i + 1)
				if (page_vld_reg[i])
					mem_reg[{page_base_reg[`EEP_ADDR_W-1:`EEP_OFFS_W], i[`EEP_OFFS_W-1:0]}]
						<= page_reg[i];
		end
	end

	// Programming timer; busy blocks every acknowledge via ST_SKIP
	// The count reloads on every commit, one cycle after the STOP
	always @(posedge clk) begin
		if (!nrst) begin
			prog_reg     <= 1'b0;
			prog_cnt_reg <= {`EEP_PROG_CNT_W{1'b0}};
		end else if (commit_reg) begin
			prog_reg     <= 1'b1;
			prog_cnt_reg <= PROG_CYCLES;
		end else if (prog_reg) begin
			// Busy falls after the last counted cycle
			if (prog_cnt_reg <= {{(`EEP_PROG_CNT_W-1){1'b0}}, 1'b1})
				prog_reg <= 1'b0;
			prog_cnt_reg <= prog_cnt_reg - {{(`EEP_PROG_CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// Open drain: output always low, enable active low while pulling
	// Busy gates the enable as a second guard, so a stale drive never
	// reaches the bus while the array is being programmed
	assign sda_out   = 1'b0;
	assign sda_oe_n  = ~(drive_low_reg & ~prog_reg);
	assign prog_busy = prog_reg;

endmodule // eep_slave

// File: sim/eep_slave_sva.sv
`timescale 1ns/1ps
// Pin-level watcher for the serial memory slave
module eep_slave_sva #(
	parameter [23:0] PROG_CYCLES = 24'd50
) (
	input wire clk,
	input wire nrst,
	input wire scl_in,
	input wire sda_in,
	input wire sda_out,
	input wire sda_oe_n,
	input wire select_pin_bit0,
	input wire select_pin_bit1,
	input wire select_pin_bit2,
	input wire write_protect,
	input wire prog_busy
);
	reg        scl_d, sda_d, in_frame;
	reg [23:0] busy_len;
	reg [3:0]  since_stop;
	wire       start_ev = scl_in & scl_d & sda_d & ~sda_in;
	wire       stop_ev  = scl_in & scl_d & ~sda_d & sda_in;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Frame state, busy length and age of the last STOP, seen from the pins only
	always @(posedge clk) begin
		scl_d <= scl_in;
		sda_d <= sda_in;
		busy_len <= prog_busy ? busy_len + 24'h1 : 24'h0;
		if (!nrst || stop_ev) in_frame <= 1'b0;
		else if (start_ev) in_frame <= 1'b1;
		if (!nrst || stop_ev) since_stop <= 4'h0;
		else if (since_stop != 4'hf) since_stop <= since_stop + 4'h1;
	end
	chk_pull_only: assert property (!sda_oe_n |-> !sda_out)
		else $error("data line driven high");
	chk_change_low: assert property ($changed(sda_oe_n) |-> !scl_in)
		else $error("data changed while clock high");
	chk_quiet_idle: assert property (!in_frame |-> sda_oe_n)
		else $error("data driven outside a frame");
	chk_busy_silent: assert property (prog_busy |-> sda_oe_n)
		else $error("acknowledge during programming");
	chk_busy_len: assert property ($fell(prog_busy) |-> busy_len == PROG_CYCLES)
		else $error("programming cycle length wrong");
	chk_busy_stop: assert property ($rose(prog_busy) |-> since_stop < 4'hc)
		else $error("programming began without a STOP");
	chk_wp_block: assert property ($rose(prog_busy) |-> !write_protect)
		else $error("programming while protected");
	chk_reset_quiet: assert property (disable iff (1'b0) !nrst |=> sda_oe_n && !prog_busy)
		else $error("outputs active in reset");
endmodule // eep_slave_sva

bind eep_slave eep_slave_sva #(.PROG_CYCLES(PROG_CYCLES)) u_sva (.clk(clk), .nrst(nrst),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
	.select_pin_bit0(select_pin_bit0), .select_pin_bit1(select_pin_bit1),
	.select_pin_bit2(select_pin_bit2), .write_protect(write_protect), .prog_busy(prog_busy));

// File: sim/eep_master.sv
`timescale 1ns/1ps
// Bus master model; the clock stands high between frames
module eep_master (
	input  wire clk,
	input  wire sda,
	output reg  scl,
	output reg  sda_low
);
	// Released lines idle high through the pull-up
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// Data moves one cycle after the clock falls, never while it is high
	task bit_io(input b, output r);
		@(posedge clk);
		sda_low <= ~b;
		repeat (3) @(posedge clk);
		scl <= 1'b1;
		repeat (2) @(posedge clk);
		r = sda;
		repeat (2) @(posedge clk);
		scl <= 1'b0;
	endtask
	task start;
		@(posedge clk);
		sda_low <= 1'b0;
		repeat (4) @(posedge clk);
		scl <= 1'b1;
		repeat (4) @(posedge clk);
		sda_low <= 1'b1;
		repeat (4) @(posedge clk);
		scl <= 1'b0;
	endtask
	task stop;
		@(posedge clk);
		sda_low <= 1'b1;
		repeat (3) @(posedge clk);
		scl <= 1'b1;
		repeat (4) @(posedge clk);
		sda_low <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	// Ninth bit released so the device can answer
	task wr_byte(input [7:0] d, output ack);
		integer i;
		reg     r;
		for (i = 7; i >= 0; i = i - 1) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	// Last byte refused so the device lets go
	task rd_byte(input last, output [7:0] d);
		integer i;
		reg     r;
		for (i = 7; i >= 0; i = i - 1) bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask
endmodule // eep_master

// File: sim/i2c_serial_eeprom_slave_tb_top.sv
`timescale 1ns/1ps
module i2c_serial_eeprom_slave_tb_top;
	reg        clk = 1'b0;
	reg        nrst = 1'b0;
	reg        wp = 1'b0;
	reg  [2:0] sel = 3'h5;
	reg        ack;
	reg  [7:0] got [0:3];
	integer    fail_count = 0;
	integer    checks_done = 0;
	wire       scl, m_low, sda_out, sda_oe_n, prog_busy;
	wire       sda = ~m_low & (sda_oe_n | sda_out); // Pull-up unless someone pulls low
	// Clock at 40 MHz
	always #12.5 clk = ~clk;
	eep_slave #(.PROG_CYCLES(24'd200)) dut (.clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .select_pin_bit0(sel[0]), .select_pin_bit1(sel[1]),
		.select_pin_bit2(sel[2]), .write_protect(wp), .prog_busy(prog_busy));
	eep_master mst (.clk(clk), .sda(sda), .scl(scl), .sda_low(m_low));
	task check(input string what, input [7:0] seen, input [7:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			fail_count = fail_count + 1;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task addr(input [15:0] a);
		mst.start;
		mst.wr_byte({4'ha, sel, 1'b0}, ack);
		check("select ack", ack, 1);
		mst.wr_byte(a[15:8], ack);
		check("high address ack", ack, 1);
		mst.wr_byte(a[7:0], ack);
		check("low address ack", ack, 1);
	endtask
	// Selective read when imm is low, else read from the current address
	task rd(input imm, input [15:0] a, input integer n);
		integer i;
		if (!imm) addr(a);
		mst.start;
		mst.wr_byte({4'ha, sel, 1'b1}, ack);
		check("read select ack", ack, 1);
		for (i = 0; i < n; i = i + 1) mst.rd_byte(i == n - 1, got[i]);
		mst.stop;
	endtask
	// Write n bytes, then poll; a poll count that runs out ends the run
	task wr(input [15:0] a, input [7:0] d, input integer n);
		integer i, k;
		addr(a);
		for (i = 0; i < n; i = i + 1) begin
			mst.wr_byte(d + i[7:0], ack);
			check("data ack", ack, 1);
		end
		mst.stop;
		k = 0;
		ack = 1'b0;
		while (!ack && k < 20) begin
			mst.start;
			mst.wr_byte({4'ha, sel, 1'b0}, ack);
			mst.stop;
			k = k + 1;
		end
		check("refused while busy", k > 1, 1);
		check("poll ack", ack, 1);
		if (!ack) close_out;
	endtask
	task t_byte;
		rd(0, 16'h0234, 1);
		check("erased byte", got[0], 8'hff);
		wr(16'h0234, 8'h5a, 1);
		rd(0, 16'he234, 1);
		check("upper bits ignored", got[0], 8'h5a);
		$display("byte write test done");
	endtask
	task t_page;
		wr(16'h045e, 8'h10, 3);
		rd(0, 16'h043f, 1);
		rd(1, 16'h0000, 1);
		check("wrapped byte", got[0], 8'h12);
		rd(0, 16'h045e, 2);
		check("page byte 0", got[0], 8'h10);
		check("page byte 1", got[1], 8'h11);
		$display("page write test done");
	endtask
	task t_wrap;
		wr(16'h1fff, 8'h77, 1);
		rd(0, 16'h1fff, 2);
		check("last location", got[0], 8'h77);
		check("location zero", got[1], 8'hff);
		$display("read wrap test done");
	endtask
	task t_refuse;
		wp <= 1'b1;
		addr(16'h0100);
		mst.wr_byte(8'h33, ack);
		check("protected data ack", ack, 0);
		mst.stop;
		repeat (8) @(posedge clk);
		check("no programming", prog_busy, 0);
		wp <= 1'b0;
		mst.start;
		mst.wr_byte({4'ha, ~sel, 1'b0}, ack);
		check("foreign select ack", ack, 0);
		mst.stop;
		rd(0, 16'h0100, 1);
		check("protected byte", got[0], 8'hff);
		$display("refusal test done");
	endtask
	// Reset, then each scenario in turn
	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		t_byte;
		t_page;
		t_wrap;
		t_refuse;
		close_out;
	end
endmodule // i2c_serial_eeprom_slave_tb_top
